// File: adc_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the converter control block.
 * Assumes a byte-wide register port with offsets as printed.
 */
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADC_OFS_CSR        8'h34
`define ADC_OFS_RESULT     8'h35
`define ADC_OFS_GAIN       8'h36

`define ADC_CSR_DONE_BIT   7
`define ADC_CSR_SPEED_BIT  6
`define ADC_CSR_PWR_BIT    5
`define ADC_CSR_CH_MSB     2
`define ADC_GAIN_SLOW_BIT  3
`define ADC_GAIN_SEL_BIT   2

`define ADC_CSR_RESET      8'h00
`define ADC_RESULT_RESET   8'h00
`define ADC_GAIN_RESET     8'h00

`define ADC_NUM_INPUTS     5
`define ADC_SAMPLE_TICKS   4
`define ADC_SAR_BITS       8

`endif

// File: adc_pkg.sv
/*
 * Types for the converter control block.
 * Assumes adc_defs.svh is on the include path.
 */
package adc_pkg;
    typedef enum logic [1:0] {
        ADC_OFF,
        ADC_SAMPLE,
        ADC_HOLD
    } adc_state_t;

    typedef struct packed {
        logic       sample;
        logic       hold;
        logic       gain_on;
        logic       power_on;
        logic [2:0] input_select;
        logic [7:0] trial;
    } adc_analog_t;
endpackage

// File: adc_sar_control.sv
/*
 * Successive-approximation converter control: registers, clock divider,
 * sample/hold sequencer and result holding.
 * Assumes the analog front end (mux, x8 gain, sample capacitor, comparator)
 * is outside; comparator answer is synchronous to clock.
 * Assumes halt_mode is synchronous; results right after a wakeup
 * from halt may be inaccurate, software must allow settling time.
 */
`timescale 1ns/1ns
`include "adc_defs.svh"

module adc_sar_control
    import adc_pkg::*;
#(
    parameter int SAMPLE_TICKS = `ADC_SAMPLE_TICKS,
    parameter int SAR_BITS     = `ADC_SAR_BITS
) (
    // system
    input  wire logic        clock,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // low-power modes
    input  wire logic        halt_mode,
    // analog front end
    input  wire logic        comparator_high,
    output adc_analog_t      analog_ctrl
);

    localparam logic [2:0] LAST_INPUT = 3'(`ADC_NUM_INPUTS - 1);
    localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_TICKS - 1);
    localparam logic [7:0] CSR_INIT    = `ADC_CSR_RESET;
    localparam logic [7:0] GAIN_INIT   = `ADC_GAIN_RESET;

    // registers
    logic [2:0]  input_select_reg, input_select_next;
    logic        speed_reg, speed_next;
    logic        power_reg, power_next;
    logic        done_reg, done_next;
    logic        slow_reg, slow_next;
    logic        gain_sel_reg, gain_sel_next;
    logic [7:0]  result_reg, result_next;
    logic [7:0]  rdata_reg, rdata_next;
    // sequencer
    adc_state_t  state_reg, state_next;
    logic [1:0]  div_reg, div_next;
    logic [2:0]  step_reg, step_next;
    logic [2:0]  tick_reg, tick_next;
    logic [7:0]  trial_reg, trial_next;
    logic [7:0]  bitmask_reg, bitmask_next;
    adc_analog_t analog_reg, analog_next;

    logic        wr_csr;
    logic        wr_gain;
    logic        rd_result;
    logic        active;
    logic        adc_tick;
    logic        finish;
    logic [7:0]  kept;
    logic [7:0]  kept_bits;

    assign wr_csr    = reg_write && reg_addr == `ADC_OFS_CSR;
    assign wr_gain   = reg_write && reg_addr == `ADC_OFS_GAIN;
    assign rd_result = reg_read && reg_addr == `ADC_OFS_RESULT;
    // halt gates off
    // power_next so the write setting power starts sampling at once
    assign active    = power_next && !halt_mode;

    // clock divider tick
    // free-running; a restart lands on any divider phase
    always_comb begin
        div_next = div_reg + 2'h1;
        if (slow_reg) begin
            adc_tick = div_reg == 2'h3;
        end else if (speed_reg) begin
            adc_tick = 1'b1;
        end else begin
            adc_tick = div_reg[0];
        end
    end

    // register file
    always_comb begin
        input_select_next = input_select_reg;
        speed_next        = speed_reg;
        power_next        = power_reg;
        slow_next         = slow_reg;
        gain_sel_next     = gain_sel_reg;
        if (wr_csr) begin
            input_select_next = reg_wdata[`ADC_CSR_CH_MSB:0];
            speed_next        = reg_wdata[`ADC_CSR_SPEED_BIT];
            power_next        = reg_wdata[`ADC_CSR_PWR_BIT];
        end
        if (wr_gain) begin
            slow_next     = reg_wdata[`ADC_GAIN_SLOW_BIT];
            gain_sel_next = reg_wdata[`ADC_GAIN_SEL_BIT];
        end
    end

    // read data, standing only in the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                `ADC_OFS_CSR: begin
                    rdata_next[`ADC_CSR_DONE_BIT]   = done_reg;
                    rdata_next[`ADC_CSR_SPEED_BIT]  = speed_reg;
                    rdata_next[`ADC_CSR_PWR_BIT]    = power_reg;
                    rdata_next[`ADC_CSR_CH_MSB:0]   = input_select_reg;
                end
                `ADC_OFS_RESULT: rdata_next = result_reg;
                `ADC_OFS_GAIN: begin
                    rdata_next[`ADC_GAIN_SLOW_BIT] = slow_reg;
                    rdata_next[`ADC_GAIN_SEL_BIT]  = gain_sel_reg;
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // per-bit keep or drop of the bit on trial
    for (genvar b = 0; b < SAR_BITS; b++) begin : g_sar_bit
        assign kept_bits[b] = bitmask_reg[b] && !comparator_high
                              ? 1'b0 : trial_reg[b];
    end

    // sequencer
    always_comb begin
        state_next   = state_reg;
        step_next    = step_reg;
        tick_next    = tick_reg;
        trial_next   = trial_reg;
        bitmask_next = bitmask_reg;
        result_next  = result_reg;
        done_next    = done_reg;
        finish       = 1'b0;
        kept         = trial_reg;
        if (!active) begin
            state_next = ADC_OFF;
        end else if (wr_csr || state_reg == ADC_OFF) begin
            state_next   = ADC_SAMPLE;
            tick_next    = 3'h0;
            trial_next   = 8'h80;
            bitmask_next = 8'h80;
            step_next    = 3'h0;
        end else if (adc_tick) begin
            unique case (state_reg)
                ADC_SAMPLE: begin
                    tick_next = tick_reg + 3'h1;
                    if (tick_reg == SAMPLE_LAST) begin
                        state_next = ADC_HOLD;
                    end
                end
                ADC_HOLD: begin
                    kept         = kept_bits;
                    bitmask_next = bitmask_reg >> 1;
                    trial_next   = kept | (bitmask_reg >> 1);
                    step_next    = step_reg + 3'h1;
                    // eight steps
                    // result takes kept, which holds the last verdict
                    if (step_reg == 3'(SAR_BITS - 1)) begin
                        finish       = 1'b1;
                        state_next   = ADC_SAMPLE;
                        tick_next    = 3'h0;
                        step_next    = 3'h0;
                        trial_next   = 8'h80;
                        bitmask_next = 8'h80;
                    end
                end
                default: state_next = ADC_OFF;
            endcase
        end
        if (finish) begin
            result_next = kept;
        end
        if (rd_result || wr_csr) begin
            done_next = 1'b0;
        end
        // set wins, no interrupt
        // finish and abort never meet: the abort branch wins
        if (finish && !wr_csr) begin
            done_next = 1'b1;
        end
    end

    // analog controls
    always_comb begin
        analog_next.sample       = active && state_next == ADC_SAMPLE;
        analog_next.hold         = active && state_next == ADC_HOLD;
        analog_next.gain_on      = active && gain_sel_next;
        analog_next.power_on     = active;
        // codes 5 to 7 route input 0, never a floating mux
        analog_next.input_select = input_select_next > LAST_INPUT
                                   ? 3'h0 : input_select_next;
        analog_next.trial        = trial_next;
    end

    // divider
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    // software registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            input_select_reg <= CSR_INIT[`ADC_CSR_CH_MSB:0];
            speed_reg        <= CSR_INIT[`ADC_CSR_SPEED_BIT];
            power_reg        <= CSR_INIT[`ADC_CSR_PWR_BIT];
            slow_reg         <= GAIN_INIT[`ADC_GAIN_SLOW_BIT];
            gain_sel_reg     <= GAIN_INIT[`ADC_GAIN_SEL_BIT];
        end else begin
            input_select_reg <= input_select_next;
            speed_reg        <= speed_next;
            power_reg        <= power_next;
            slow_reg         <= slow_next;
            gain_sel_reg     <= gain_sel_next;
        end
    end

    // read data
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // sequencer and status
    always_ff @(posedge clock) begin
        if (!resetn) begin
            done_reg    <= CSR_INIT[`ADC_CSR_DONE_BIT];
            result_reg  <= `ADC_RESULT_RESET;
            state_reg   <= ADC_OFF;
            step_reg    <= 3'h0;
            tick_reg    <= 3'h0;
            trial_reg   <= 8'h80;
            bitmask_reg <= 8'h80;
        end else begin
            done_reg    <= done_next;
            result_reg  <= result_next;
            state_reg   <= state_next;
            step_reg    <= step_next;
            tick_reg    <= tick_next;
            trial_reg   <= trial_next;
            bitmask_reg <= bitmask_next;
        end
    end

    // analog controls, registered so every output is a flip-flop
    always_ff @(posedge clock) begin
        if (!resetn) begin
            analog_reg <= '0;
        end else begin
            analog_reg <= analog_next;
        end
    end

    assign reg_rdata   = rdata_reg;
    assign analog_ctrl = analog_reg;

endmodule

// File: adc_sar_control_properties.sv
/* port checker for the converter control block.
   assumes it is bound onto every adc_sar_control instance. */
`timescale 1ns/1ns
module adc_sar_control_properties
    import adc_pkg::*;
(
    // system
    input wire logic       clock,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // low power and analog side
    input wire logic       halt_mode,
    input wire logic       comparator_high,
    input adc_analog_t     analog_ctrl
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    gain_unused_a: assert property (
        $past(reg_read) && $past(reg_addr) == 8'h36
        |-> (reg_rdata & 8'hF3) == 8'h00) else $error("gain spare bits set");
    gain_power_a: assert property (
        analog_ctrl.gain_on |-> analog_ctrl.power_on)
        else $error("gain on without power");
    halt_off_a: assert property (
        halt_mode |=> !analog_ctrl.power_on) else $error("halt left power on");
    phase_excl_a: assert property (
        !(analog_ctrl.sample && analog_ctrl.hold))
        else $error("sample and hold together");
    hold_full_a: assert property (
        $fell(analog_ctrl.hold) && !$past(reg_write) && !$past(halt_mode)
        |-> $past(analog_ctrl.hold, 8)) else $error("hold under 8 cycles");
    trial_msb_a: assert property (
        $rose(analog_ctrl.hold) |-> analog_ctrl.trial == 8'h80)
        else $error("first trial not msb");
    csr_restart_a: assert property (
        reg_write && reg_addr == 8'h34 && reg_wdata[5] && !halt_mode
        |=> analog_ctrl.sample && !analog_ctrl.hold)
        else $error("control write did not restart");
    power_off_a: assert property (
        reg_write && reg_addr == 8'h34 && !reg_wdata[5]
        |=> !analog_ctrl.power_on && !analog_ctrl.gain_on)
        else $error("power bit clear left converter on");
    chan_route_a: assert property (
        reg_write && reg_addr == 8'h34 && reg_wdata[2:0] <= 3'h4
        |=> analog_ctrl.input_select == $past(reg_wdata[2:0]))
        else $error("channel not routed");
endmodule

bind adc_sar_control adc_sar_control_properties i_props (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .halt_mode(halt_mode),
    .comparator_high(comparator_high), .analog_ctrl(analog_ctrl));

// File: adc_front_model.sv
/* analog side model: mux, x8 gain, sample capacitor, comparator.
   assumes the bench drives one level byte per input. */
`timescale 1ns/1ns
module adc_front_model
    import adc_pkg::*;
(
    // bench side
    input wire logic [4:0][7:0] levels,
    // converter side
    input wire logic            clock,
    input adc_analog_t          analog_ctrl,
    output logic                comparator_high
);
    logic [7:0]  cap;
    logic [10:0] amp;
    always @(posedge clock)
        if (analog_ctrl.sample && analog_ctrl.input_select <= 3'h4)
            cap <= levels[analog_ctrl.input_select];
    // x8 gain, clipped at full scale
    assign amp = analog_ctrl.gain_on ? {cap, 3'h0} : {3'h0, cap};
    // compare against trial only in hold
    assign comparator_high = analog_ctrl.hold &&
        ((amp > 11'h0FF ? 11'h0FF : amp) >= {3'h0, analog_ctrl.trial});
endmodule

// File: adc_sar_control_tb_top.sv
/* bench for the converter control block.
   assumes adc_front_model stands in for the analog side. */
`timescale 1ns/1ns
`include "adc_defs.svh"
module adc_sar_control_tb_top;
    import adc_pkg::*;
    logic            clock = 1'b0;
    logic            resetn = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [7:0]      reg_wdata = 8'h00;
    logic            reg_write = 1'b0;
    logic            reg_read = 1'b0;
    logic [7:0]      reg_rdata;
    logic            halt_mode = 1'b0;
    logic            comparator_high;
    adc_analog_t     analog_ctrl;
    logic [4:0][7:0] levels = {8'h00, 8'hA5, 8'h3C, 8'h5A, 8'hFF};
    int              error_cnt = 0;
    int              samples_checked = 0;
    logic [7:0]      d;

    always #4 clock = ~clock;

    adc_sar_control i_adc_sar_control (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .halt_mode(halt_mode),
        .comparator_high(comparator_high), .analog_ctrl(analog_ctrl));
    adc_front_model i_adc_front_model (.levels(levels), .clock(clock),
        .analog_ctrl(analog_ctrl), .comparator_high(comparator_high));

    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_done;
        for (int i = 0; i < 300; i++) begin
            rd(`ADC_OFS_CSR, d);
            if (d[7] === 1'b1)
                return;
        end
        error_cnt++;
        summarize();
    endtask
    task automatic conv(input logic [7:0] c, e);
        wr(`ADC_OFS_CSR, c);
        wait_done();
        rd(`ADC_OFS_RESULT, d);
        chk("result", d, e);
    endtask
    task automatic hold_len(input logic [7:0] g, c, input int n);
        int k;
        wr(`ADC_OFS_GAIN, g);
        wr(`ADC_OFS_CSR, c);
        #1;
        for (k = 0; k < 200 && analog_ctrl.hold !== 1'b1; k++)
            @(posedge clock) #1;
        for (k = 0; k < 100 && analog_ctrl.hold === 1'b1; k++)
            @(posedge clock) #1;
        chk("hold cycles", k[7:0], n[7:0]);
    endtask

    task automatic t_reset;
        rd(`ADC_OFS_CSR, d);
        chk("csr reset", d, 8'h00);
        rd(`ADC_OFS_RESULT, d);
        chk("result reset", d, 8'h00);
        rd(`ADC_OFS_GAIN, d);
        chk("gain reset", d, 8'h00);
    endtask
    task automatic t_chan;
        conv(8'h67, levels[0]);
        for (int c = 0; c < 5; c++)
            conv(8'h60 | 8'(c), levels[c]);
        rd(`ADC_OFS_CSR, d);
        chk("done clr", d, 8'h64);
    endtask
    task automatic t_hold;
        conv(8'h63, 8'hA5);
        levels[3] <= 8'h11;
        rd(`ADC_OFS_RESULT, d);
        chk("held", d, 8'hA5);
        wait_done();
        rd(`ADC_OFS_RESULT, d);
        wait_done();
        rd(`ADC_OFS_RESULT, d);
        chk("next", d, 8'h11);
        wr(`ADC_OFS_CSR, 8'h63);
        rd(`ADC_OFS_CSR, d);
        chk("abort", d, 8'h63);
    endtask
    task automatic t_gain;
        wr(`ADC_OFS_GAIN, 8'hFF);
        rd(`ADC_OFS_GAIN, d);
        chk("gain rd", d, 8'h0C);
        // slowest divider with gain; 2 MHz is out of reach here
        wr(`ADC_OFS_GAIN, 8'h0C);
        levels[1] <= 8'h10;
        conv(8'h21, 8'h80);
        chk("gain on", {7'h0, analog_ctrl.gain_on}, 8'h01);
        levels[1] <= 8'h30;
        conv(8'h21, 8'hFF);
    endtask
    task automatic t_off;
        @(posedge clock);
        halt_mode <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("halt", {7'h0, analog_ctrl.power_on}, 8'h00);
        @(posedge clock);
        halt_mode <= 1'b0;
        wr(`ADC_OFS_GAIN, 8'h04);
        wr(`ADC_OFS_CSR, 8'h00);
        #1 chk("off", {6'h0, analog_ctrl.gain_on, analog_ctrl.power_on},
               8'h00);
        rd(8'h37, d);
        chk("unmapped", d, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_chan();
        t_hold();
        t_gain();
        hold_len(8'h00, 8'h60, 8);
        hold_len(8'h00, 8'h20, 16);
        hold_len(8'h08, 8'h60, 32);
        t_off();
        summarize();
    end
endmodule
